//--- sim/keypad_model.sv
`timescale 1ns/1ps
module keypad_model (
  input  wire        aclk,
  input  wire        kp_present,
  input  wire        kp_req,
  input  wire        kp_we,
  input  wire [3:0]  kp_addr,
  input  wire [15:0] kp_wdata,
  input  wire [3:0]  slow,
  output logic       kp_ack,
  output logic       kp_err,
  output logic [15:0] kp_rdata
);
  logic [15:0] mem [16];
  logic [3:0]  cnt;
  initial begin
    kp_ack = 1'b0;
    kp_err = 1'b0;
    kp_rdata = 16'h0;
    cnt = 4'h0;
    for (int i = 0; i < 16; i++)
      mem[i] = 16'h0a00 + 16'(i);
  end
  // a detached keypad never answers; idle data lines toggle
  always @(posedge aclk) begin
    if (kp_req && !kp_ack && kp_present) begin
      if (cnt < slow) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
        kp_ack <= 1'b1;
        kp_err <= 1'b0;
        kp_rdata <= mem[kp_addr];
        if (kp_we)
          mem[kp_addr] <= kp_wdata;
      end
    end else if (!kp_req && kp_ack) begin
      kp_ack <= 1'b0;
      kp_rdata <= ~kp_rdata;
    end else if (!kp_ack) begin
      kp_rdata <= ~kp_rdata;
    end
  end
endmodule // keypad_model

//--- sim/opcc_props.sv
`timescale 1ns/1ps
`include "opcc_regs.vh"
module opcc_props (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        kp_present,
  input wire        kp_ack,
  input wire        kp_req,
  input wire        kp_we,
  input wire [3:0]  kp_addr,
  input wire [15:0] kp_wdata,
  input wire [5:0]  line2_monitor,
  input wire [5:0]  line3_monitor,
  input wire [15:0] speed_ref,
  input wire        panel_fault,
  input wire        motor_stop
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic dec_w_r;
  // remembers whether the accepted write address is unmapped
  always @(posedge aclk)
    if (s_axi_awvalid && s_axi_awready)
      dec_w_r <= s_axi_awaddr > `A_PDAT;
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_read_decode: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && (s_axi_rresp == `RESP_DEC) ==
    ($past(s_axi_araddr) > `A_PDAT)) else $error("bad read answer");
  a_write_decode: assert property (s_axi_bvalid |-> s_axi_bresp ==
    (dec_w_r ? `RESP_DEC : `RESP_OK)) else $error("bad write resp");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_kp_payload: assert property (kp_req && $past(kp_req) |->
    $stable(kp_addr) && $stable(kp_we) && $stable(kp_wdata))
    else $error("keypad payload moved");
  a_kp_wait: assert property (kp_req && !kp_ack &&
    !$past(kp_ack) && !$past(kp_ack, 2) && kp_present &&
    $past(kp_present) && $past(kp_present, 2) |=> kp_req)
    else $error("keypad request dropped before answer");
  a_line_range: assert property (line2_monitor >= `MON_MIN &&
    line2_monitor <= `MON_MAX && line3_monitor >= `MON_MIN &&
    line3_monitor <= `MON_MAX) else $error("line monitor out of range");
  a_reset_state: assert property (disable iff (1'b0) !aresetn
    |=> line2_monitor == `L2_RST && line3_monitor == `L3_RST &&
    !panel_fault && !motor_stop && !kp_req && speed_ref == 16'h0)
    else $error("bad reset state");
  a_fault_cause: assert property ($rose(panel_fault) |->
    !$past(kp_present, 2) || !$past(kp_present, 3) ||
    !$past(kp_present, 4)) else $error("fault without removal");
  a_stop_cause: assert property (motor_stop |-> !kp_present ||
    !$past(kp_present, 2) || !$past(kp_present, 3) ||
    !$past(kp_present, 4)) else $error("stop without removal");
endmodule // opcc_props
bind operator_panel_config_copy opcc_props props_u (.*);

//--- sim/testbench.sv
`timescale 1ns/1ps
`include "opcc_regs.vh"
module testbench;
  logic        aclk, aresetn, kp_present, serial_active;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, v;
  logic [3:0]  s_axi_wstrb, slow;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, run_cmd, out_voltage;
  logic        key_up, key_down, key_enter, key_reset;
  logic [1:0]  rsp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, kp_ack, kp_err;
  wire         kp_req, kp_we, panel_fault, motor_stop;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  kp_rdata, kp_wdata, speed_ref;
  wire [3:0]   kp_addr;
  wire [5:0]   line2_monitor, line3_monitor;
  int          bad_count, samples_checked;
  operator_panel_config_copy #(.sec_cycles(32'd10),
    .save_cycles(32'd20), .hour_secs(12'd3)) dut_u (.*);
  keypad_model kp_u (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ready is sampled at the falling edge, where it equals its edge value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) da = 1'b1;
      if (s_axi_wvalid && s_axi_wready) dw = 1'b1;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic idle;
    do rd(`A_STAT, v); while (v[1]);
  endtask
  task automatic press(input int i);
    @(posedge aclk);
    case (i)
      0: key_up <= 1'b1;
      1: key_down <= 1'b1;
      2: key_enter <= 1'b1;
      default: key_reset <= 1'b1;
    endcase
    repeat (4) @(posedge aclk);
    {key_up, key_down, key_enter, key_reset} <= 4'h0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic t_regs;
    rd(`A_CTRL, v);
    chk("ctrl reset", v, 32'h1e);
    rd(`A_DISP, v);
    chk("disp reset", v, 32'h0302);
    rd(8'h40, v);
    chk("unmapped read", v, 32'h0);
    chk("unmapped rresp", rsp, 2'h3);
    wr(8'h40, 32'h1);
    chk("unmapped write", rsp, 2'h3);
  endtask
  task automatic t_lines;
    wr(`A_MON, 32'h00140a35);
    rd(`A_DISP, v);
    chk("sequential lines", v, 32'h0201);
    chk("line2 port", line2_monitor, 6'h01);
    wr(`A_CTRL, 32'h1f);
    rd(`A_DISP, v);
    chk("locked lines", v, 32'h140a);
    wr(`A_MON, 32'h00143605);
    rd(`A_DISP, v);
    chk("out of range sel", v, 32'h140a);
    chk("line3 port", line3_monitor, 6'h14);
    wr(`A_CTRL, 32'h1e);
  endtask
  task automatic t_user;
    // every parameter word gets a known value before any copy
    for (int i = 0; i < 16; i++) begin
      wr(`A_PIDX, i);
      wr(`A_PDAT, 32'h0b00 + i);
    end
    wr(`A_PIDX, 32'h3);
    wr(`A_PDAT, 32'h1234);
    wr(`A_UDEF, 32'h1);
    idle();
    chk("user stored", v[5], 1'b1);
    wr(`A_PDAT, 32'h5555);
    wr(`A_INIT, 32'h456);
    idle();
    rd(`A_PDAT, v);
    chk("restored", v[15:0], 16'h1234);
    wr(`A_UDEF, 32'h2);
    idle();
    chk("user cleared", v[5], 1'b0);
    wr(`A_PDAT, 32'h7777);
    wr(`A_INIT, 32'h456);
    idle();
    rd(`A_PDAT, v);
    chk("no restore", v[15:0], 16'h7777);
  endtask
  task automatic t_speed;
    wr(`A_SPD, 32'h100);
    press(0);
    press(0);
    chk("immediate", speed_ref, 16'h102);
    rd(`A_SPD, v);
    chk("not yet stored", v[31:16], 16'h100);
    repeat (30) @(posedge aclk);
    rd(`A_SPD, v);
    chk("stored later", v[31:16], 16'h102);
    wr(`A_CTRL, 32'h1c);
    press(1);
    chk("held edit", speed_ref, 16'h102);
    press(2);
    chk("confirmed", speed_ref, 16'h101);
    wr(`A_CTRL, 32'h1e);
  endtask
  task automatic t_unplug(input logic [31:0] c, input logic f, s);
    wr(`A_CTRL, c);
    kp_present <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("fault", panel_fault, f);
    chk("stop", motor_stop, s);
    kp_present <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
  task automatic t_disc;
    t_unplug(32'h1e, 1'b1, 1'b0);
    chk("fault held", panel_fault, 1'b1);
    press(3);
    chk("fault reset", panel_fault, 1'b0);
    t_unplug(32'h1a, 1'b0, 1'b1);
    t_unplug(32'h12, 1'b0, 1'b0);
  endtask
  task automatic t_hours;
    wr(`A_CTRL, 32'h0e);
    wr(`A_HRS, 32'hfffe);
    repeat (100) @(posedge aclk);
    rd(`A_HRS, v);
    chk("power hours", v[15:0], 16'hffff);
    wr(`A_CTRL, 32'h1e);
    wr(`A_HRS, 32'h0);
    repeat (100) @(posedge aclk);
    rd(`A_HRS, v);
    chk("stopped hours", v[15:0], 16'h0);
    for (int i = 0; i < 2; i++) begin
      {run_cmd, out_voltage} <= i ? 2'b01 : 2'b10;
      repeat (70) @(posedge aclk);
      {run_cmd, out_voltage} <= 2'b00;
      rd(`A_HRS, v);
      chk("running hours", v[15:0], 16'(2 * i + 2));
    end
  endtask
  task automatic t_copy;
    wr(`A_COPY, 32'h1);
    idle();
    chk("no permission", v[4:2], 3'h5);
    press(2);
    rd(`A_COPY, v);
    chk("dismissed", v, 32'h0);
    wr(`A_CTRL, 32'h3e);
    slow <= 4'h3;
    wr(`A_COPY, 32'h1);
    wr(`A_COPY, 32'h3);
    rd(`A_COPY, v);
    chk("busy ignores", v, 32'h1);
    idle();
    chk("read ok", v[4:2], 3'h0);
    chk("keypad word", kp_u.mem[3], 16'h7777);
    slow <= 4'h0;
    wr(`A_PDAT, 32'h1111);
    wr(`A_COPY, 32'h3);
    idle();
    chk("mismatch", v[4:2], 3'h7);
    press(0);
    wr(`A_COPY, 32'h2);
    idle();
    rd(`A_PDAT, v);
    chk("written", {rsp, v[15:0]}, {2'h0, 16'h7777});
    wr(`A_COPY, 32'h3);
    idle();
    chk("verify ok", v[4:2], 3'h0);
    wr(`A_COPY, 32'h2);
    kp_present <= 1'b0;
    idle();
    chk("cut transfer", v[4:2], 3'h6);
    kp_present <= 1'b1;
    press(3);
    rd(`A_COPY, v);
    chk("cut dismissed", v, 32'h0);
    serial_active <= 1'b1;
    wr(`A_PDAT, 32'h2222);
    wr(`A_COPY, 32'h1);
    rd(`A_STAT, v);
    chk("serial blocks", v[1], 1'b0);
    chk("keypad kept", kp_u.mem[3], 16'h7777);
    serial_active <= 1'b0;
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, serial_active} = 3'h0;
    {key_up, key_down, key_enter, key_reset} = 4'h0;
    {run_cmd, out_voltage} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    slow = 4'h0;
    kp_present = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_lines();
    t_user();
    t_speed();
    t_disc();
    t_hours();
    t_copy();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end
endmodule // testbench

//--- src/opcc_regs.vh
`ifndef OPCC_REGS_VH
`define OPCC_REGS_VH
// register byte addresses
`define A_CTRL 8'h00
`define A_MON 8'h04
`define A_DISP 8'h08
`define A_UDEF 8'h0c
`define A_INIT 8'h10
`define A_SPD 8'h14
`define A_HRS 8'h18
`define A_COPY 8'h1c
`define A_STAT 8'h20
`define A_PIDX 8'h24
`define A_PDAT 8'h28
// control register fields
`define B_LAYOUT 0
`define B_METHOD 1
`define B_DISC 2
`define B_HKEY 3
`define B_ESRC 4
`define B_RPERM 5
`define CTRL_W 6
`define CTRL_RST 6'h1e
// monitor numbers
`define MON_MIN 6'h01
`define MON_MAX 6'h35
`define TOP_RST 6'h01
`define L2_RST 6'h02
`define L3_RST 6'h03
// command codes
`define UD_SAVE 2'h1
`define UD_CLR 2'h2
`define INIT_USER 16'h0456
`define CP_NONE 2'h0
`define CP_READ 2'h1
`define CP_WRITE 2'h2
`define CP_VERIFY 2'h3
// copy result codes
`define E_NONE 2'h0
`define E_PERM 2'h1
`define E_XFER 2'h2
`define E_VER 2'h3
// parameter store
`define PAW 4
`define PLAST 4'hf
`define HRS_MAX 16'hffff
// timing
`define CLK_HZ 200000000
`define SPD_SAVE_S 5
`define HOUR_S 3600
`define RESP_OK 2'h0
`define RESP_DEC 2'h3
`endif

//--- src/operator_panel_config_copy.v
`timescale 1ns/1ps
`include "opcc_regs.vh"
module operator_panel_config_copy #(
  parameter [31:0] sec_cycles = `CLK_HZ,
  parameter [31:0] save_cycles = `SPD_SAVE_S * `CLK_HZ,
  parameter [11:0] hour_secs = `HOUR_S
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        kp_present,
  input  wire        key_up,
  input  wire        key_down,
  input  wire        key_enter,
  input  wire        key_reset,
  input  wire        serial_active,
  input  wire        run_cmd,
  input  wire        out_voltage,
  input  wire        kp_ack,
  input  wire        kp_err,
  input  wire [15:0] kp_rdata,
  output reg         kp_req,
  output reg         kp_we,
  output reg  [3:0]  kp_addr,
  output reg  [15:0] kp_wdata,
  output reg  [5:0]  line2_monitor,
  output reg  [5:0]  line3_monitor,
  output reg  [15:0] speed_ref,
  output reg         panel_fault,
  output reg         motor_stop
);
  localparam [2:0] S_IDLE = 3'd0, S_LOCAL = 3'd1, S_REQ = 3'd2,
                   S_ACK = 3'd3, S_REL = 3'd4;
  localparam [2:0] OP_SAVE = 3'd0, OP_REST = 3'd1, OP_READ = 3'd2,
                   OP_WRITE = 3'd3, OP_VER = 3'd4;

  function [5:0] mon_step;
    input [5:0] m;
    begin
      mon_step = (m >= `MON_MAX) ? `MON_MIN : m + 6'h01;
    end
  endfunction

  function valid_mon;
    input [5:0] m;
    begin
      valid_mon = (m >= `MON_MIN) && (m <= `MON_MAX);
    end
  endfunction

  // pin synchronisers
  reg  [8:0]  s1_r;
  reg  [8:0]  s2_r;
  reg  [8:0]  prev_r;
  reg  [15:0] d1_r;
  reg  [15:0] d2_r;
  wire [8:0]  pins = {kp_err, kp_ack, serial_active, key_reset,
                      key_enter, key_down, key_up, kp_present, 1'b0};
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 9'h000;
      s2_r <= 9'h000;
      prev_r <= 9'h000;
      d1_r <= 16'h0000;
      d2_r <= 16'h0000;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      prev_r <= s2_r;
      d1_r <= kp_rdata;
      d2_r <= d1_r;
    end
  end
  wire present_s = s2_r[1];
  wire serial_s = s2_r[6];
  wire ack_s = s2_r[7];
  wire err_s = s2_r[8];
  wire up_p = s2_r[2] & ~prev_r[2];
  wire dn_p = s2_r[3] & ~prev_r[3];
  wire ent_p = s2_r[4] & ~prev_r[4];
  wire rst_p = s2_r[5] & ~prev_r[5];
  wire any_p = up_p | dn_p | ent_p | rst_p;
  wire keys_held = s2_r[2] | s2_r[3];
  wire removed_p = ~present_s & prev_r[1];

  // AXI4-Lite slave
  reg         aw_ok_r;
  reg         w_ok_r;
  reg  [7:0]  awa_r;
  reg  [31:0] wd_r;
  reg  [3:0]  ws_r;
  reg  [31:0] rmux;
  reg         hit;
  wire        both = aw_ok_r & w_ok_r;
  wire        wr_go = both & ~s_axi_bvalid;
  wire        rd_go = s_axi_arvalid & s_axi_arready;
  wire [7:0]  mux_a = both ? awa_r : s_axi_araddr;
  wire [31:0] bm = {{8{ws_r[3]}}, {8{ws_r[2]}},
                    {8{ws_r[1]}}, {8{ws_r[0]}}};
  wire [31:0] wv = (wd_r & bm) | (rmux & ~bm);
  assign s_axi_awready = ~aw_ok_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_ok_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid & ~both;
  wire wr_ctrl = wr_go & (awa_r == `A_CTRL);
  wire wr_mon = wr_go & (awa_r == `A_MON);
  wire wr_udef = wr_go & (awa_r == `A_UDEF);
  wire wr_init = wr_go & (awa_r == `A_INIT);
  wire wr_spd = wr_go & (awa_r == `A_SPD);
  wire wr_hrs = wr_go & (awa_r == `A_HRS);
  wire wr_copy = wr_go & (awa_r == `A_COPY);
  wire wr_pidx = wr_go & (awa_r == `A_PIDX);
  wire wr_pdat = wr_go & (awa_r == `A_PDAT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OK;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_ok_r <= 1'b1;
        awa_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_ok_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit ? `RESP_OK : `RESP_DEC;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux;
        s_axi_rresp <= hit ? `RESP_OK : `RESP_DEC;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control and configuration state
  reg [`CTRL_W-1:0] ctrl_r;
  reg [5:0]  top_r;
  reg [5:0]  sel2_r;
  reg [5:0]  sel3_r;
  reg [15:0] spd_edit_r;
  reg [15:0] spd_store_r;
  reg        dirty_r;
  reg [31:0] rel_cnt_r;
  reg [31:0] sec_cnt_r;
  reg [11:0] sec_hr_r;
  reg [15:0] hours_r;
  reg [`PAW-1:0] pidx_r;
  reg [15:0] param_mem [0:15];
  reg [15:0] user_mem [0:15];
  reg        user_ok_r;
  reg [2:0]  st_r;
  reg [2:0]  op_r;
  reg [`PAW-1:0] idx_r;
  reg [1:0]  copy_sel_r;
  reg [1:0]  result_r;
  reg        copy_err_r;
  reg        mism_r;
  reg        xerr_r;

  wire layout = ctrl_r[`B_LAYOUT];
  wire immed = ctrl_r[`B_METHOD];
  wire disc_opt = ctrl_r[`B_DISC];
  wire hkey = ctrl_r[`B_HKEY];
  wire running = run_cmd | out_voltage;
  wire busy = (st_r != S_IDLE);

  always @* begin
    hit = 1'b1;
    rmux = 32'h00000000;
    case (mux_a)
      `A_CTRL: rmux = {26'h0, ctrl_r};
      `A_MON: rmux = {10'h0, sel3_r, 2'h0, sel2_r, 2'h0, top_r};
      `A_DISP: rmux = {18'h0, line3_monitor, 2'h0, line2_monitor};
      `A_UDEF: rmux = 32'h00000000;
      `A_INIT: rmux = 32'h00000000;
      `A_SPD: rmux = {spd_store_r, speed_ref};
      `A_HRS: rmux = {16'h0, hours_r};
      `A_COPY: rmux = {30'h0, copy_sel_r};
      `A_STAT: rmux = {24'h0, panel_fault, motor_stop, user_ok_r,
                       copy_err_r, result_r, busy, present_s};
      `A_PIDX: rmux = {28'h0, pidx_r};
      `A_PDAT: rmux = {16'h0, param_mem[pidx_r]};
      default: hit = 1'b0;
    endcase
  end

  // configuration, monitor lines, hours, fault
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CTRL_RST;
      top_r <= `TOP_RST;
      sel2_r <= `L2_RST;
      sel3_r <= `L3_RST;
      line2_monitor <= `L2_RST;
      line3_monitor <= `L3_RST;
      pidx_r <= {`PAW{1'b0}};
      sec_cnt_r <= 32'h00000000;
      sec_hr_r <= 12'h000;
      hours_r <= 16'h0000;
      panel_fault <= 1'b0;
      motor_stop <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= wv[`CTRL_W-1:0];
      if (wr_mon) begin
        if (valid_mon(wv[5:0]))
          top_r <= wv[5:0];
        if (valid_mon(wv[13:8]))
          sel2_r <= wv[13:8];
        if (valid_mon(wv[21:16]))
          sel3_r <= wv[21:16];
      end
      if (wr_pidx)
        pidx_r <= wv[`PAW-1:0];
      if (layout) begin
        line2_monitor <= sel2_r;
        line3_monitor <= sel3_r;
      end else begin
        line2_monitor <= mon_step(top_r);
        line3_monitor <= mon_step(mon_step(top_r));
      end
      if (wr_hrs) begin
        hours_r <= wv[15:0];
        sec_cnt_r <= 32'h00000000;
        sec_hr_r <= 12'h000;
      end else if (!ctrl_r[`B_ESRC] || running) begin
        if (sec_cnt_r >= sec_cycles - 32'h1) begin
          sec_cnt_r <= 32'h00000000;
          if (sec_hr_r >= hour_secs - 12'h1) begin
            sec_hr_r <= 12'h000;
            if (hours_r != `HRS_MAX)
              hours_r <= hours_r + 16'h0001;
          end else begin
            sec_hr_r <= sec_hr_r + 12'h001;
          end
        end else begin
          sec_cnt_r <= sec_cnt_r + 32'h1;
        end
      end
      if (disc_opt && removed_p)
        panel_fault <= 1'b1;
      else if (present_s && rst_p)
        panel_fault <= 1'b0;
      // removal with the option off stops only if hand key is on
      motor_stop <= ~present_s & ~disc_opt & hkey;
    end
  end

  // keypad speed entry
  always @(posedge aclk) begin
    if (!aresetn) begin
      spd_edit_r <= 16'h0000;
      spd_store_r <= 16'h0000;
      speed_ref <= 16'h0000;
      dirty_r <= 1'b0;
      rel_cnt_r <= 32'h00000000;
    end else begin
      if (wr_spd) begin
        spd_edit_r <= wv[15:0];
        speed_ref <= wv[15:0];
        spd_store_r <= wv[15:0];
        dirty_r <= 1'b0;
      end else if (up_p || dn_p) begin
        if (up_p && spd_edit_r != 16'hffff) begin
          spd_edit_r <= spd_edit_r + 16'h0001;
          if (immed)
            speed_ref <= spd_edit_r + 16'h0001;
        end else if (dn_p && spd_edit_r != 16'h0000) begin
          spd_edit_r <= spd_edit_r - 16'h0001;
          if (immed)
            speed_ref <= spd_edit_r - 16'h0001;
        end
        dirty_r <= immed;
        rel_cnt_r <= 32'h00000000;
      end else if (!immed && ent_p) begin
        speed_ref <= spd_edit_r;
        spd_store_r <= spd_edit_r;
      end else if (immed && dirty_r) begin
        if (keys_held) begin
          rel_cnt_r <= 32'h00000000;
        end else if (rel_cnt_r >= save_cycles - 32'h1) begin
          spd_store_r <= spd_edit_r;
          dirty_r <= 1'b0;
          rel_cnt_r <= 32'h00000000;
        end else begin
          rel_cnt_r <= rel_cnt_r + 32'h1;
        end
      end
    end
  end

  // parameter stores and copy engine
  wire last = (idx_r == `PLAST);
  wire [1:0] cp_cmd = wv[1:0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= S_IDLE;
      op_r <= OP_SAVE;
      idx_r <= {`PAW{1'b0}};
      user_ok_r <= 1'b0;
      copy_sel_r <= `CP_NONE;
      result_r <= `E_NONE;
      copy_err_r <= 1'b0;
      mism_r <= 1'b0;
      xerr_r <= 1'b0;
      kp_req <= 1'b0;
      kp_we <= 1'b0;
      kp_addr <= 4'h0;
      kp_wdata <= 16'h0000;
    end else begin
      if (wr_pdat && !busy)
        param_mem[pidx_r] <= wv[15:0];
      if (copy_err_r && any_p) begin
        copy_err_r <= 1'b0;
        copy_sel_r <= `CP_NONE;
      end
      case (st_r)
        S_IDLE: begin
          idx_r <= {`PAW{1'b0}};
          mism_r <= 1'b0;
          xerr_r <= 1'b0;
          if (wr_udef && wv[1:0] == `UD_SAVE) begin
            op_r <= OP_SAVE;
            st_r <= S_LOCAL;
          end else if (wr_udef && wv[1:0] == `UD_CLR) begin
            user_ok_r <= 1'b0;
          end else if (wr_init && wv[15:0] == `INIT_USER &&
                       user_ok_r) begin
            op_r <= OP_REST;
            st_r <= S_LOCAL;
          end else if (wr_copy && cp_cmd != `CP_NONE &&
                       !serial_s && !copy_err_r) begin
            copy_sel_r <= cp_cmd;
            result_r <= `E_NONE;
            if (cp_cmd == `CP_READ && !ctrl_r[`B_RPERM]) begin
              result_r <= `E_PERM;
              copy_err_r <= 1'b1;
            end else begin
              st_r <= S_REQ;
              case (cp_cmd)
                `CP_READ: op_r <= OP_READ;
                `CP_WRITE: op_r <= OP_WRITE;
                default: op_r <= OP_VER;
              endcase
            end
          end
        end
        S_LOCAL: begin
          if (op_r == OP_SAVE)
            user_mem[idx_r] <= param_mem[idx_r];
          else
            param_mem[idx_r] <= user_mem[idx_r];
          idx_r <= idx_r + 4'h1;
          if (last) begin
            if (op_r == OP_SAVE)
              user_ok_r <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_REQ: begin
          kp_req <= 1'b1;
          kp_we <= (op_r == OP_READ);
          kp_addr <= idx_r;
          kp_wdata <= param_mem[idx_r];
          st_r <= S_ACK;
        end
        S_ACK: begin
          if (!present_s) begin
            kp_req <= 1'b0;
            xerr_r <= 1'b1;
            st_r <= S_REL;
          end else if (ack_s) begin
            kp_req <= 1'b0;
            if (err_s)
              xerr_r <= 1'b1;
            else if (op_r == OP_WRITE)
              param_mem[idx_r] <= d2_r;
            else if (op_r == OP_VER && d2_r != param_mem[idx_r])
              mism_r <= 1'b1;
            st_r <= S_REL;
          end
        end
        S_REL: begin
          if (!ack_s || !present_s) begin
            if (xerr_r || last) begin
              st_r <= S_IDLE;
              if (xerr_r || mism_r) begin
                copy_err_r <= 1'b1;
                result_r <= xerr_r ? `E_XFER : `E_VER;
              end else begin
                copy_sel_r <= `CP_NONE;
              end
            end else begin
              idx_r <= idx_r + 4'h1;
              st_r <= S_REQ;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule // operator_panel_config_copy
